// ==== inc/hbm_regs.svh ====
/*
 constants for the hub mode and strap block: timing, reset and mode values.
 assumes inclusion by bare name from design files.
*/
`ifndef HBM_REGS_SVH
`define HBM_REGS_SVH
`define HBM_CLK_MHZ 250
`define HBM_SYNC_STAGES 2
`define HBM_STRAP_RST 2'h0
`define HBM_DRV_RST 8'h55 // all four pin enables released
`define HBM_MODE_HUB 1'h1
`endif

// ==== inc/hbm_pkg.sv ====
/*
 types for the hub mode and strap block.
 assumes nothing beyond a systemverilog compiler.
*/
package hbm_pkg;
   // operating mode of the device
   typedef enum logic [1:0] {
      HBM_STANDBY,
      HBM_HUB,
      HBM_BYPASS
   } hbm_mode_t;
   // one differential pair as two-signal pins
   typedef struct packed {
      logic pos_o;
      logic pos_oe_n;
      logic neg_o;
      logic neg_oe_n;
   } hbm_pair_drv_t;
   // hub datapath drive for one pair
   typedef struct packed {
      logic pos;
      logic neg;
      logic en;
   } hbm_hub_pair_t;
endpackage

// ==== verilog/hbm_sync.sv ====
/*
 two-flop synchroniser for a bus of pin levels.
 assumes inputs asynchronous to clock; output read after second stage.
*/
`timescale 1ns/1ps
module hbm_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   // two stages, first read only by second
   always_ff @(posedge clock) begin
      if (srst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end
   assign dout = sync_q;
endmodule

// ==== verilog/hbm_mode_strap.sv ====
/*
 mode select and port-disable strap logic of a three-port hub.
 assumes pins arrive asynchronous; hub datapath and analog switch outside.
*/
`timescale 1ns/1ps
`include "hbm_regs.svh"
module hbm_mode_strap #(
   parameter int NPORT = 3
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic bypass_sel_n,
   input wire logic reset_pin_n,
   input wire logic [1:0] downstream_pos_lines_p1_p2,
   input wire logic [1:0] downstream_neg_lines_p1_p2,
   input wire logic [NPORT-1:0] pair_swap_setting,
   input wire hbm_pkg::hbm_hub_pair_t [NPORT-1:0] hub_drv,
   output hbm_pkg::hbm_pair_drv_t [1:0] downstream_p1_p2_drv,
   output logic bypass_switch_on,
   output logic [NPORT-1:0] swap_eff,
   output logic [NPORT-1:0] port_enable,
   output logic core_low_power,
   output logic core_reset,
   output hbm_pkg::hbm_mode_t mode
);
   logic [5:0] raw;
   logic [5:0] syn;
   logic byp_n_s;
   logic rst_n_s;
   logic rst_n_prev_q;
   logic [1:0] dis_q;
   logic [1:0] dis_d;
   logic [1:0] strap_both_w;
   logic release_w;
   logic bypass_w;
   logic hub_w;
   logic [NPORT-1:0] en_w;
   hbm_pkg::hbm_mode_t mode_d;
   hbm_pkg::hbm_pair_drv_t [1:0] drv_d;
   assign raw = {downstream_neg_lines_p1_p2, downstream_pos_lines_p1_p2,
      reset_pin_n, bypass_sel_n};
   // all pin inputs pass two flops
   hbm_sync #(.W(6)) u_sync (
      .clock(clock),
      .srst(srst),
      .din(raw),
      .dout(syn)
   );
   assign byp_n_s = syn[0];
   assign rst_n_s = syn[1];
   // decode of mode and release edge
   assign release_w = rst_n_s & ~rst_n_prev_q;
   assign bypass_w = rst_n_s & ~byp_n_s;
   assign hub_w = rst_n_s & byp_n_s;
   assign mode_d = !rst_n_s ? hbm_pkg::HBM_STANDBY :
      (bypass_w ? hbm_pkg::HBM_BYPASS : hbm_pkg::HBM_HUB);
   // strap sampled once at release, held after
   // a port asks for disable only with both lines high
   assign strap_both_w = syn[3:2] & syn[5:4];
   assign dis_d = release_w ? strap_both_w : dis_q;
   // port enables: port3 never strap-disabled
   assign en_w = {1'b1, ~dis_d};
   // downstream 1/2 drive: float in bypass or standby
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_dn
         assign drv_d[g].pos_o = hub_drv[g].pos;
         assign drv_d[g].neg_o = hub_drv[g].neg;
         assign drv_d[g].pos_oe_n = ~(hub_w & en_w[g] & hub_drv[g].en);
         assign drv_d[g].neg_oe_n = ~(hub_w & en_w[g] & hub_drv[g].en);
         // disabled or floated port keeps both lines released
         property p_dis_float;
            @(posedge clock) disable iff (srst)
            (!hub_w || !en_w[g]) |=> (downstream_p1_p2_drv[g].pos_oe_n
               && downstream_p1_p2_drv[g].neg_oe_n);
         endproperty
         a_dis_float: assert property (p_dis_float) else $error("port not floated");
         // enabled port in hub mode follows the hub datapath
         property p_drive;
            @(posedge clock) disable iff (srst)
            (hub_w && en_w[g] && hub_drv[g].en) |=> (!downstream_p1_p2_drv[g].pos_oe_n
               && downstream_p1_p2_drv[g].pos_o == $past(hub_drv[g].pos));
         endproperty
         a_drive: assert property (p_drive) else $error("port not driven");
      end
   endgenerate
   // registered outputs
   always_ff @(posedge clock) begin
      if (srst) begin
         rst_n_prev_q <= 1'b0;
         dis_q <= `HBM_STRAP_RST;
         mode <= hbm_pkg::HBM_STANDBY;
         bypass_switch_on <= 1'b0;
         swap_eff <= '0;
         port_enable <= '0;
         core_low_power <= 1'b1;
         core_reset <= 1'b1;
         downstream_p1_p2_drv <= `HBM_DRV_RST;
      end else begin
         rst_n_prev_q <= rst_n_s;
         dis_q <= dis_d;
         mode <= mode_d;
         bypass_switch_on <= bypass_w;
         swap_eff <= bypass_w ? '0 : pair_swap_setting;
         port_enable <= hub_w ? en_w : '0;
         core_low_power <= ~hub_w;
         core_reset <= ~rst_n_s;
         downstream_p1_p2_drv <= drv_d;
      end
   end
   // low mode select closes the bypass switch
   property p_bypass_switch;
      @(posedge clock) disable iff (srst)
      (rst_n_s && !byp_n_s) |=> bypass_switch_on;
   endproperty
   a_bypass_switch: assert property (p_bypass_switch) else $error("switch not on");
   // low mode select shows bypass mode one edge later
   property p_mode_bypass;
      @(posedge clock) disable iff (srst)
      bypass_w |=> (mode == hbm_pkg::HBM_BYPASS) && (port_enable == '0);
   endproperty
   a_mode_bypass: assert property (p_mode_bypass) else $error("bypass mode not shown");
   // bypass releases all four lines of ports 1 and 2
   property p_float;
      @(posedge clock) disable iff (srst)
      bypass_switch_on |-> (downstream_p1_p2_drv[0].pos_oe_n
         && downstream_p1_p2_drv[0].neg_oe_n && downstream_p1_p2_drv[1].pos_oe_n
         && downstream_p1_p2_drv[1].neg_oe_n);
   endproperty
   a_float: assert property (p_float) else $error("ports 1/2 driven in bypass");
   // bypass keeps the core in reduced power
   property p_lowpow;
      @(posedge clock) disable iff (srst)
      bypass_switch_on |-> core_low_power;
   endproperty
   a_lowpow: assert property (p_lowpow) else $error("core not in low power");
   // high mode select runs the hub
   property p_hub;
      @(posedge clock) disable iff (srst)
      (rst_n_s && byp_n_s) |=> (mode == hbm_pkg::HBM_HUB) && port_enable[2];
   endproperty
   a_hub: assert property (p_hub) else $error("hub mode not entered");
   // hub mode passes the swap setting through at full power
   property p_swap_hub;
      @(posedge clock) disable iff (srst)
      hub_w |=> (swap_eff == $past(pair_swap_setting)) && !core_low_power;
   endproperty
   a_swap_hub: assert property (p_swap_hub) else $error("hub swap or power wrong");
   // port3 stays enabled whenever the hub runs
   property p_port3;
      @(posedge clock) disable iff (srst)
      (mode == hbm_pkg::HBM_HUB) |-> port_enable[NPORT-1];
   endproperty
   a_port3: assert property (p_port3) else $error("port3 disabled in hub mode");
   // swap never reaches the bypass path
   property p_noswap;
      @(posedge clock) disable iff (srst)
      bypass_switch_on |-> (swap_eff == '0);
   endproperty
   a_noswap: assert property (p_noswap) else $error("swap active in bypass");
   // straps taken at the release edge
   property p_strap;
      @(posedge clock) disable iff (srst)
      release_w |=> (dis_q == $past(strap_both_w));
   endproperty
   a_strap: assert property (p_strap) else $error("strap not sampled");
   // straps frozen between releases
   property p_hold;
      @(posedge clock) disable iff (srst)
      !release_w |=> $stable(dis_q);
   endproperty
   a_hold: assert property (p_hold) else $error("strap changed without release");
   // reset pin low holds standby
   property p_standby;
      @(posedge clock) disable iff (srst)
      !rst_n_s |=> core_reset && core_low_power && (port_enable == '0);
   endproperty
   a_standby: assert property (p_standby) else $error("standby not held");
   // standby floats ports 1 and 2 too
   property p_standby_float;
      @(posedge clock) disable iff (srst)
      !rst_n_s |=> (downstream_p1_p2_drv[0].pos_oe_n && downstream_p1_p2_drv[0].neg_oe_n
         && downstream_p1_p2_drv[1].pos_oe_n && downstream_p1_p2_drv[1].neg_oe_n);
   endproperty
   a_standby_float: assert property (p_standby_float) else $error("port driven in standby");
   // released reset pin lets the core out of reset
   property p_run;
      @(posedge clock) disable iff (srst)
      rst_n_s |=> !core_reset && (mode != hbm_pkg::HBM_STANDBY);
   endproperty
   a_run: assert property (p_run) else $error("core held in reset");
   // mode select high again leaves bypass without reset
   property p_restore;
      @(posedge clock) disable iff (srst)
      (bypass_switch_on && rst_n_s && byp_n_s) |=> !bypass_switch_on && !core_low_power;
   endproperty
   a_restore: assert property (p_restore) else $error("hub not restored");
   // main scenarios
   c_bypass: cover property (@(posedge clock) disable iff (srst)
      !bypass_switch_on ##1 bypass_switch_on);
   c_restore: cover property (@(posedge clock) disable iff (srst)
      bypass_switch_on ##1 !bypass_switch_on);
   c_disabled: cover property (@(posedge clock) disable iff (srst)
      release_w && strap_both_w != 2'h0);
   c_both_off: cover property (@(posedge clock) disable iff (srst)
      release_w && strap_both_w == 2'h3);
   c_standby: cover property (@(posedge clock) disable iff (srst)
      rst_n_prev_q && !rst_n_s);
endmodule

// ==== tb/hbm_host.sv ====
/* system processor model: drives mode, reset and strap pins.
 assumes the bench sets the requests; pins move at the falling edge. */
`timescale 1ns/1ps
module hbm_host (
   input wire logic clock,
   input wire logic go_bypass,
   input wire logic go_run,
   input wire logic [1:0] strap_pos,
   input wire logic [1:0] strap_neg,
   output logic bypass_sel_n,
   output logic reset_pin_n,
   output logic [1:0] pos_pins,
   output logic [1:0] neg_pins
);
   // pins follow the requests, away from the sampling edge
   always @(negedge clock) begin
      bypass_sel_n <= !go_bypass;
      reset_pin_n <= go_run;
      pos_pins <= strap_pos;
      neg_pins <= strap_neg;
   end
endmodule

// ==== tb/test_hub_bypass_mode_and_port_straps.sv ====
/* self-checking bench for the hub mode and strap block.
 assumes the host model drives the pins; outputs settle 3 edges later. */
`timescale 1ns/1ps
module test_hub_bypass_mode_and_port_straps;
   logic clock = 0;
   logic srst = 1;
   logic go_bypass = 0;
   logic go_run = 0;
   logic [1:0] sp = 2'h0;
   logic [1:0] sn = 2'h0;
   logic [2:0] swap = 3'h0;
   logic bsel_n, rpin_n, sw_on, lp, crst;
   logic [1:0] pp, np;
   logic [2:0] swap_eff, pen;
   hbm_pkg::hbm_hub_pair_t [2:0] hub_drv;
   hbm_pkg::hbm_pair_drv_t [1:0] drv;
   hbm_pkg::hbm_mode_t mode;
   int err_count = 0;
   int n_tests = 0;
   assign hub_drv = {3{hbm_pkg::hbm_hub_pair_t'(3'h5)}};
   // clock, 4 ns period
   always #2 clock = ~clock;
   hbm_host host (.clock(clock), .go_bypass(go_bypass), .go_run(go_run),
      .strap_pos(sp), .strap_neg(sn), .bypass_sel_n(bsel_n), .reset_pin_n(rpin_n),
      .pos_pins(pp), .neg_pins(np));
   hbm_mode_strap uut (.clock(clock), .srst(srst), .bypass_sel_n(bsel_n),
      .reset_pin_n(rpin_n), .downstream_pos_lines_p1_p2(pp),
      .downstream_neg_lines_p1_p2(np), .pair_swap_setting(swap), .hub_drv(hub_drv),
      .downstream_p1_p2_drv(drv), .bypass_switch_on(sw_on), .swap_eff(swap_eff),
      .port_enable(pen), .core_low_power(lp), .core_reset(crst), .mode(mode));
   // compare one value
   task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] seen);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // let pins pass synchroniser and register
   task automatic settle();
      repeat (6) @(negedge clock);
   endtask
   task automatic summarize();
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // reset pin low keeps standby
   task automatic t_standby();
      settle();
      chk("mode", hbm_pkg::HBM_STANDBY, mode);
      chk("core_reset", 1, crst);
      chk("low_power", 1, lp);
      chk("port_enable", 0, pen);
      chk("switch", 0, sw_on);
      chk("oe_n", 4'hF, {drv[0].pos_oe_n, drv[0].neg_oe_n, drv[1].pos_oe_n,
         drv[1].neg_oe_n});
   endtask
   // strap sampled at release, then held
   task automatic t_strap();
      sp = 2'h3;
      sn = 2'h1;
      swap = 3'h5;
      go_run = 1;
      settle();
      chk("port_enable", 3'h6, pen);
      chk("mode", hbm_pkg::HBM_HUB, mode);
      chk("swap_eff", 3'h5, swap_eff);
      chk("low_power", 0, lp);
      chk("core_reset", 0, crst);
      chk("switch", 0, sw_on);
      chk("p1_oe_n", 2'h3, {drv[0].pos_oe_n, drv[0].neg_oe_n});
      chk("p2_drive", 4'h8, {drv[1].pos_o, drv[1].neg_o, drv[1].pos_oe_n,
         drv[1].neg_oe_n});
      sn = 2'h3;
      settle();
      chk("held", 3'h6, pen);
   endtask
   // bypass and back to hub
   task automatic t_bypass();
      go_bypass = 1;
      settle();
      chk("mode", hbm_pkg::HBM_BYPASS, mode);
      chk("switch", 1, sw_on);
      chk("oe_n", 4'hF, {drv[0].pos_oe_n, drv[0].neg_oe_n, drv[1].pos_oe_n,
         drv[1].neg_oe_n});
      chk("low_power", 1, lp);
      chk("swap_eff", 0, swap_eff);
      go_bypass = 0;
      settle();
      chk("mode", hbm_pkg::HBM_HUB, mode);
      chk("swap_eff", 3'h5, swap_eff);
      chk("p2_oe_n", 0, drv[1].pos_oe_n);
   endtask
   // reset pin drops mid-run, straps taken again at the new release
   task automatic t_rerelease();
      go_run = 0;
      sp = 2'h3;
      sn = 2'h3;
      settle();
      chk("mode", hbm_pkg::HBM_STANDBY, mode);
      chk("core_reset", 1, crst);
      chk("low_power", 1, lp);
      chk("port_enable", 0, pen);
      chk("oe_n", 4'hF, {drv[0].pos_oe_n, drv[0].neg_oe_n, drv[1].pos_oe_n,
         drv[1].neg_oe_n});
      go_run = 1;
      settle();
      chk("port_enable", 3'h4, pen);
      chk("oe_n", 4'hF, {drv[0].pos_oe_n, drv[0].neg_oe_n, drv[1].pos_oe_n,
         drv[1].neg_oe_n});
      sp = 2'h0;
      sn = 2'h0;
      settle();
      chk("held", 3'h4, pen);
   endtask
   initial begin
      repeat (20) @(negedge clock);
      srst = 0;
      t_standby();
      t_strap();
      t_bypass();
      t_rerelease();
      summarize();
   end
endmodule
